//--- rtl/cpm_regs.svh
// Constants for the codec power-mode control block
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH
`define CPM_CLK_MHZ 125
`define CPM_REF_WAKE_NS 200000
`define CPM_ADC_WAKE_NS 3000
`define CPM_DAC_WAKE_NS 10000
`define CPM_WAKE_CYC(ns) ((((ns) * `CPM_CLK_MHZ) + 999) / 1000)
`define CPM_BIT_DAC_EN 0
`define CPM_BIT_ADC_EN 1
`define CPM_BIT_REF_EN 2
`define CPM_BIT_CONT 3
`define CPM_BIT_SRC 4
`define CPM_BIT_ADC_ADDR 5
`define CPM_BIT_DAC_ADDR 6
`define CPM_BIT_START 7
`define CPM_LAST_BIT 3'h7
`define CPM_DAC_RESET 8'h00
`define CPM_CODE_ZERO 8'h00
`define CPM_CODE_MAX 8'hff
`define CPM_CODE_STEPS 17'sh0_0100
`endif

//--- rtl/cpm_pkg.sv
// Types shared by the codec power-mode control block
package cpm_pkg;
  typedef enum logic [2:0] {
    CPM_RX_HUNT = 3'b001,
    CPM_RX_CTRL = 3'b010,
    CPM_RX_DATA = 3'b100
  } cpm_rx_state_t;

  typedef enum logic [4:0] {
    CPM_PWR_OFF = 5'b00001,
    CPM_PWR_REF = 5'b00010,
    CPM_PWR_REF_ADC = 5'b00100,
    CPM_PWR_REF_DAC = 5'b01000,
    CPM_PWR_ALL = 5'b10000
  } cpm_pwr_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } cpm_pins_t;

  typedef struct packed {
    logic reference_power_enable;
    logic adc_power_enable;
    logic dac_power_enable;
  } cpm_enables_t;
endpackage : cpm_pkg

//--- rtl/cpm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cpm_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : cpm_sync

//--- rtl/cpm_fifo.sv
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/10ps
module cpm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Drain accepts
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; count guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : cpm_fifo

//--- rtl/cpm_top.sv
// Codec power-mode, input-select and DAC preload control
`timescale 1ns/10ps
`include "cpm_regs.svh"
module cpm_top
  import cpm_pkg::*;
#(
  parameter int REF_WAKE_CYCLES = `CPM_WAKE_CYC(`CPM_REF_WAKE_NS),
  parameter int FIFO_DEPTH = 16,
  parameter int SAMPLE_W = 16
) (
  input wire logic core_clk, // 125 MHz core clock
  input wire logic nrst, // Async reset, active low
  input wire logic link_cs_n, // Chip select pin, active low
  input wire logic link_sclk, // Serial clock pin
  input wire logic link_din, // Serial data pin
  input wire logic signed [SAMPLE_W-1:0] analog_input_pin, // Pin level, half-step units
  input wire logic signed [SAMPLE_W-1:0] half_supply_sample, // Half supply, half-step units
  input wire logic dac_core_ready, // DAC core takes a byte
  output logic reference_power_enable, // Reference on
  output logic adc_power_enable, // ADC on
  output logic dac_power_enable, // DAC on
  output cpm_pwr_t power_state, // Decoded power state
  output logic input_source_select, // 1 half supply, 0 pin
  output logic continuous_conversion_select, // Continuous mode
  output logic [2:0] wake_ready, // Settled: {ref, adc, dac}
  output logic conv_start, // Pulse: conversion begins
  output logic [7:0] adc_code, // Last conversion code
  output logic [7:0] dac_reg, // DAC data register
  output logic [7:0] dac_out_code, // Code driven to DAC core
  output logic dac_fifo_ready // DAC byte FIFO has room
);
  localparam int ADC_WAKE = `CPM_WAKE_CYC(`CPM_ADC_WAKE_NS);
  localparam int DAC_WAKE = `CPM_WAKE_CYC(`CPM_DAC_WAKE_NS);
  localparam int TW = 16;

  logic rst_meta_q, rst_n_q;
  cpm_pins_t pins_raw, pins_s, pins_prev_q;
  cpm_rx_state_t rx_q, rx_d;
  logic [7:0] shift_q, shift_d;
  logic [2:0] cnt_q, cnt_d;
  logic word_done, byte_done, abort, sclk_rise;
  logic [2:0] en_q, en_d;
  logic src_q, src_d, cont_q, cont_d, conv_q, conv_d;
  logic [7:0] dac_reg_q, dac_reg_d, dac_out_q, dac_out_d, code_q, code_d;
  cpm_pwr_t pwr_q, pwr_d;
  logic fifo_in_ready, fifo_out_valid, fifo_ready_q, pop;
  logic [7:0] fifo_out_data;
  logic [2:0] ready_q;
  logic signed [SAMPLE_W-1:0] sample_sel;

  function automatic cpm_pwr_t pwr_decode(input logic [2:0] en);
    if (!en[`CPM_BIT_REF_EN]) begin
      pwr_decode = CPM_PWR_OFF;
    end else if (en[`CPM_BIT_ADC_EN] && en[`CPM_BIT_DAC_EN]) begin
      pwr_decode = CPM_PWR_ALL;
    end else if (en[`CPM_BIT_ADC_EN]) begin
      pwr_decode = CPM_PWR_REF_ADC;
    end else if (en[`CPM_BIT_DAC_EN]) begin
      pwr_decode = CPM_PWR_REF_DAC;
    end else begin
      pwr_decode = CPM_PWR_REF;
    end
  endfunction : pwr_decode

  // Input in half-step units; +1 then halve centres each transition
  function automatic logic [7:0] adc_map(input logic signed [SAMPLE_W-1:0] s);
    logic signed [SAMPLE_W:0] t;
    // A one-bit signed one would read as minus one, so widen it first
    t = ($signed({s[SAMPLE_W-1], s}) + $signed((SAMPLE_W + 1)'(1))) >>> 1;
    if (s < 0) begin
      adc_map = `CPM_CODE_ZERO;
    end else if (t >= `CPM_CODE_STEPS) begin
      adc_map = `CPM_CODE_MAX;
    end else begin
      adc_map = t[7:0];
    end
  endfunction : adc_map

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  assign pins_raw = '{cs_n: link_cs_n, sclk: link_sclk, din: link_din};

  cpm_sync #(.W(3)) u_pin_sync (
    .clk(core_clk),
    .rst_n(rst_n_q),
    .d(pins_raw),
    .q(pins_s)
  );

  // Serial receiver
  always_comb begin
    rx_d = rx_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    word_done = 1'b0;
    byte_done = 1'b0;
    abort = 1'b0;
    sclk_rise = pins_s.sclk && !pins_prev_q.sclk;
    if (pins_s.cs_n) begin
      abort = !pins_prev_q.cs_n && (rx_q == CPM_RX_CTRL);
      rx_d = CPM_RX_HUNT;
      cnt_d = '0;
    end else if (sclk_rise) begin
      unique case (rx_q)
        CPM_RX_HUNT: begin
          if (pins_s.din) begin
            shift_d = 8'h01;
            cnt_d = 3'h1;
            rx_d = CPM_RX_CTRL;
          end
        end
        CPM_RX_CTRL: begin
          shift_d = {shift_q[6:0], pins_s.din};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == `CPM_LAST_BIT) begin
            word_done = 1'b1;
            rx_d = shift_d[`CPM_BIT_DAC_ADDR] ? CPM_RX_DATA : CPM_RX_HUNT;
          end
        end
        CPM_RX_DATA: begin
          shift_d = {shift_q[6:0], pins_s.din};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == `CPM_LAST_BIT) begin
            byte_done = 1'b1;
            rx_d = cont_q ? CPM_RX_DATA : CPM_RX_HUNT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_q <= CPM_RX_HUNT;
      shift_q <= '0;
      cnt_q <= '0;
      pins_prev_q <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    end else begin
      rx_q <= rx_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      pins_prev_q <= pins_s;
    end
  end

  // Control word application and conversion start
  always_comb begin
    en_d = en_q;
    src_d = src_q;
    cont_d = cont_q;
    conv_d = 1'b0;
    if (abort) begin
      en_d = '0;
      cont_d = 1'b0;
    end else if (word_done) begin
      en_d[`CPM_BIT_DAC_EN] = shift_d[`CPM_BIT_DAC_EN];
      en_d[`CPM_BIT_ADC_EN] = shift_d[`CPM_BIT_ADC_EN];
      en_d[`CPM_BIT_REF_EN] = shift_d[`CPM_BIT_REF_EN];
      src_d = shift_d[`CPM_BIT_SRC];
      cont_d = shift_d[`CPM_BIT_CONT];
      // Waking or mux-changing word only sets up acquisition
      conv_d = shift_d[`CPM_BIT_ADC_ADDR] && shift_d[`CPM_BIT_ADC_EN]
               && en_q[`CPM_BIT_ADC_EN] && (shift_d[`CPM_BIT_SRC] == src_q);
    end
    pwr_d = pwr_decode(en_d);
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_q <= '0;
      src_q <= 1'b0;
      cont_q <= 1'b0;
      conv_q <= 1'b0;
      pwr_q <= CPM_PWR_OFF;
    end else begin
      en_q <= en_d;
      src_q <= src_d;
      cont_q <= cont_d;
      conv_q <= conv_d;
      pwr_q <= pwr_d;
    end
  end

  // DAC bytes buffered; the DAC core drains at its own pace
  cpm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_dac_fifo (
    .clk(core_clk),
    .rst_n(rst_n_q),
    .in_valid(byte_done),
    .in_ready(fifo_in_ready),
    .in_data(shift_d),
    .out_valid(fifo_out_valid),
    .out_ready(dac_core_ready),
    .out_data(fifo_out_data)
  );

  assign pop = fifo_out_valid && dac_core_ready;
  assign sample_sel = src_q ? half_supply_sample : analog_input_pin;

  // DAC register, output code and ADC result
  always_comb begin
    dac_reg_d = dac_reg_q;
    code_d = code_q;
    if (abort) begin
      dac_reg_d = `CPM_DAC_RESET;
    end else if (pop) begin
      dac_reg_d = fifo_out_data;
    end
    // Output holds zero while off, preload appears on enable
    dac_out_d = en_d[`CPM_BIT_DAC_EN] ? dac_reg_d : `CPM_DAC_RESET;
    if (conv_q) begin
      code_d = adc_map(sample_sel);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dac_reg_q <= `CPM_DAC_RESET;
      dac_out_q <= `CPM_DAC_RESET;
      code_q <= `CPM_CODE_ZERO;
      fifo_ready_q <= 1'b0;
    end else begin
      dac_reg_q <= dac_reg_d;
      dac_out_q <= dac_out_d;
      code_q <= code_d;
      fifo_ready_q <= fifo_in_ready;
    end
  end

  // Wake-up timers, one per enable
  for (genvar i = 0; i < 3; i++) begin : g_wake
    localparam int LIM = (i == `CPM_BIT_REF_EN) ? REF_WAKE_CYCLES
                       : (i == `CPM_BIT_ADC_EN) ? ADC_WAKE : DAC_WAKE;
    logic [TW-1:0] tmr_q, tmr_d;
    logic rdy_d;
    always_comb begin
      tmr_d = '0;
      rdy_d = 1'b0;
      if (en_q[i]) begin
        rdy_d = (tmr_q >= TW'(LIM));
        tmr_d = rdy_d ? tmr_q : tmr_q + 1'b1;
      end
    end
    always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        tmr_q <= '0;
        ready_q[i] <= 1'b0;
      end else begin
        tmr_q <= tmr_d;
        ready_q[i] <= rdy_d;
      end
    end
  end

  assign reference_power_enable = en_q[`CPM_BIT_REF_EN];
  assign adc_power_enable = en_q[`CPM_BIT_ADC_EN];
  assign dac_power_enable = en_q[`CPM_BIT_DAC_EN];
  assign power_state = pwr_q;
  assign input_source_select = src_q;
  assign continuous_conversion_select = cont_q;
  assign wake_ready = ready_q;
  assign conv_start = conv_q;
  assign adc_code = code_q;
  assign dac_reg = dac_reg_q;
  assign dac_out_code = dac_out_q;
  assign dac_fifo_ready = fifo_ready_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n_q);

  sequence adc_wakes_s;
    $rose(en_q[`CPM_BIT_ADC_EN]);
  endsequence
  sequence adc_settles_s;
    ##[1:380] (ready_q[`CPM_BIT_ADC_EN] || !en_q[`CPM_BIT_ADC_EN]);
  endsequence

  abort_shutdown_a: assert property (abort |=> (en_q == '0) && (dac_reg_q == 8'h00))
    else $error("abort did not reach full shutdown");
  word_hold_a: assert property (!word_done && !abort |=> $stable(en_q) && $stable(src_q))
    else $error("settings changed without a full control word");
  mux_no_conv_a: assert property (word_done && (shift_d[`CPM_BIT_SRC] != src_q) |=> !conv_q)
    else $error("conversion started on mux change word");
  wake_no_conv_a: assert property (word_done && !en_q[`CPM_BIT_ADC_EN] |=> !conv_q)
    else $error("conversion started on waking word");
  adc_early_a: assert property (adc_wakes_s |-> !ready_q[`CPM_BIT_ADC_EN] [*8])
    else $error("adc ready too soon");
  adc_late_a: assert property (adc_wakes_s |-> adc_settles_s)
    else $error("adc ready too late");
  code_clamp_a: assert property (conv_q && (sample_sel < 0) |=> code_q == 8'h00)
    else $error("negative input gave nonzero code");
  half_sel_a: assert property (conv_q && src_q |=> code_q == adc_map($past(half_supply_sample)))
    else $error("half supply not selected");
  dac_preload_a: assert property ($rose(en_q[`CPM_BIT_DAC_EN]) |-> dac_out_q == dac_reg_q)
    else $error("preloaded value not output on enable");
  dac_off_a: assert property (!en_q[`CPM_BIT_DAC_EN] |-> dac_out_q == 8'h00)
    else $error("dac output active while disabled");
endmodule : cpm_top

//--- test/cpm_host_model.sv
// Serial host model driving the three-wire control link
`timescale 1ns/10ps
module cpm_host_model (
  input wire logic core_clk, // Core clock
  output logic link_cs_n, // Chip select, active low
  output logic link_sclk, // Serial clock
  output logic link_din // Serial data
);
  localparam int HALF = 10; // 80 ns half period of the link clock

  initial begin
    link_cs_n = 1'b1;
    link_sclk = 1'b0;
    link_din = 1'b0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge core_clk);
  endtask : wait_half

  task automatic open_frame();
    @(posedge core_clk);
    link_cs_n <= 1'b0;
    wait_half();
  endtask : open_frame

  // Data set while the clock is low, taken on the rise
  task automatic shift_bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_din <= v[i];
      wait_half();
      link_sclk <= 1'b1;
      wait_half();
      link_sclk <= 1'b0;
    end
  endtask : shift_bits

  // No pull on the data line, so idle shows the inverse of the last bit
  task automatic close_frame();
    wait_half();
    link_cs_n <= 1'b1;
    link_din <= ~link_din;
    wait_half();
  endtask : close_frame
endmodule : cpm_host_model

//--- test/tb_cpm_top.sv
// Self-checking bench for the codec power-mode control block
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module tb_cpm_top
  import cpm_pkg::*;
;
  typedef struct packed {logic [7:0] w; cpm_pwr_t ps;} cpm_row_t;
  typedef struct packed {logic [15:0] s; logic [7:0] c;} cpm_smp_t;
  logic core_clk, nrst, link_cs_n, link_sclk, link_din, dac_core_ready;
  logic signed [15:0] analog_input_pin, half_supply_sample;
  logic reference_power_enable, adc_power_enable, dac_power_enable;
  cpm_pwr_t power_state;
  logic input_source_select, continuous_conversion_select, conv_start, dac_fifo_ready;
  logic [2:0] wake_ready;
  logic [7:0] adc_code, dac_reg, dac_out_code;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int conv_cnt = 0;
  int tr, ta, td, n;
  cpm_row_t rows [8] = '{'{8'h80, CPM_PWR_OFF}, '{8'h84, CPM_PWR_REF}, '{8'h86, CPM_PWR_REF_ADC},
    '{8'h85, CPM_PWR_REF_DAC}, '{8'h87, CPM_PWR_ALL}, '{8'h83, CPM_PWR_OFF},
    '{8'h9f, CPM_PWR_ALL}, '{8'h81, CPM_PWR_OFF}};
  cpm_smp_t smp [8] = '{'{16'hfffb, 8'h00}, '{16'h0000, 8'h00}, '{16'h0001, 8'h01},
    '{16'h0002, 8'h01}, '{16'h0003, 8'h02}, '{16'h01fc, 8'hfe}, '{16'h01fd, 8'hff},
    '{16'h0258, 8'hff}};

  cpm_top #(.REF_WAKE_CYCLES(50)) u_cpm_top (.core_clk, .nrst, .link_cs_n, .link_sclk,
    .link_din, .analog_input_pin, .half_supply_sample, .dac_core_ready,
    .reference_power_enable, .adc_power_enable, .dac_power_enable, .power_state,
    .input_source_select, .continuous_conversion_select, .wake_ready, .conv_start,
    .adc_code, .dac_reg, .dac_out_code, .dac_fifo_ready);
  cpm_host_model u_cpm_host_model (.core_clk, .link_cs_n, .link_sclk, .link_din);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (conv_start === 1'b1) conv_cnt <= conv_cnt + 1;
  end

  // Whole run is about 10000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic stop_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic word(input logic [15:0] v, input int nb);
    u_cpm_host_model.open_frame();
    u_cpm_host_model.shift_bits(v, nb);
    u_cpm_host_model.close_frame();
  endtask : word

  // Cycles from the ADC enable showing until each settled flag rises
  task automatic measure();
    n = 0;
    tr = 0;
    ta = 0;
    td = 0;
    while (adc_power_enable !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    for (int i = 1; i < 1400; i++) begin
      @(posedge core_clk);
      #1;
      if (tr == 0 && wake_ready[2] === 1'b1) tr = i;
      if (ta == 0 && wake_ready[1] === 1'b1) ta = i;
      if (td == 0 && wake_ready[0] === 1'b1) td = i;
    end
  endtask : measure

  initial begin
    nrst = 1'b0;
    dac_core_ready = 1'b1;
    analog_input_pin = 16'h0000;
    half_supply_sample = 16'h00c8;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK({reference_power_enable, adc_power_enable, dac_power_enable, dac_out_code, wake_ready, adc_code}, 0);
    `CHK({power_state, dac_reg}, {CPM_PWR_OFF, 8'h00});
    fork
      word(16'h0087, 8);
      measure();
    join
    `CHK(tr >= 49 && tr <= 53, 1);
    `CHK(ta >= 374 && ta <= 378, 1);
    `CHK(td >= 1249 && td <= 1253, 1);
    foreach (rows[i]) begin
      word({3'b000, rows[i].w}, 11);
      `CHK({reference_power_enable, adc_power_enable, dac_power_enable}, rows[i].w[2:0]);
      `CHK(power_state, rows[i].ps);
      `CHK({input_source_select, continuous_conversion_select}, rows[i].w[4:3]);
    end
    n = conv_cnt;
    word(16'h00a6, 8);
    `CHK(conv_cnt - n, 0);
    // Host keeps the settling time before the first conversion
    repeat (380) @(posedge core_clk);
    `CHK(wake_ready[2:1], 2'b11);
    foreach (smp[i]) begin
      @(posedge core_clk);
      analog_input_pin <= smp[i].s;
      word(16'h00a6, 8);
      `CHK(conv_cnt - n, i + 1);
      `CHK(adc_code, smp[i].c);
    end
    n = conv_cnt;
    word(16'h00b6, 8);
    `CHK({8'(conv_cnt - n), input_source_select}, {8'h00, 1'b1});
    word(16'h00b6, 8);
    `CHK({8'(conv_cnt - n), adc_code}, {8'h01, 8'h64});
    word(16'hc45a, 16);
    `CHK({dac_power_enable, dac_reg, dac_out_code}, {1'b0, 8'h5a, 8'h00});
    word(16'h0085, 8);
    `CHK({dac_power_enable, dac_out_code}, {1'b1, 8'h5a});
    word(16'h0087, 8);
    u_cpm_host_model.open_frame();
    u_cpm_host_model.shift_bits(16'h0008, 4);
    `CHK(dac_power_enable, 1);
    u_cpm_host_model.close_frame();
    `CHK({reference_power_enable, adc_power_enable, dac_power_enable, dac_reg}, 0);
    `CHK(power_state, CPM_PWR_OFF);
    // Far side stalls while continuous DAC bytes overfill the buffer
    @(posedge core_clk);
    dac_core_ready <= 1'b0;
    u_cpm_host_model.open_frame();
    u_cpm_host_model.shift_bits(16'h00cd, 8);
    for (int i = 1; i <= 17; i++) begin
      u_cpm_host_model.shift_bits(16'(8'h10 + i), 8);
      if (i == 15) `CHK(dac_fifo_ready, 1);
    end
    `CHK(dac_fifo_ready, 0);
    @(posedge core_clk);
    dac_core_ready <= 1'b1;
    repeat (40) @(posedge core_clk);
    `CHK({dac_fifo_ready, dac_reg, dac_out_code}, {1'b1, 8'h20, 8'h20});
    u_cpm_host_model.close_frame();
    // Mid-run reset must clear the loaded DAC value and settled flags
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK({dac_power_enable, dac_reg, dac_out_code, wake_ready}, 0);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK({power_state, dac_fifo_ready, adc_code}, {CPM_PWR_OFF, 1'b1, 8'h00});
    stop_test();
  end
endmodule : tb_cpm_top
